// ---- rtl/pmic_regs_pkg.sv ----
package pmic_regs_pkg;
  localparam logic [9:0] ADDR_PAGE_CTL0 = 10'h000;
  localparam logic [9:0] ADDR_PAGE_CTL1 = 10'h080;
  localparam logic [9:0] ADDR_PAGE_CTL2 = 10'h100;
  localparam logic [9:0] ADDR_PAGE_CTL4 = 10'h200;
  localparam logic [9:0] ADDR_IN_STATUS = 10'h050;
  localparam logic [9:0] ADDR_REG_STATUS = 10'h051;
  localparam logic [9:0] ADDR_IN_EVENT = 10'h052;
  localparam logic [9:0] ADDR_REG_EVENT = 10'h053;
  localparam logic [9:0] ADDR_IN_MASK = 10'h054;
  localparam logic [9:0] ADDR_REG_MASK = 10'h055;
  localparam logic [9:0] ADDR_CONTROL = 10'h056;
  localparam logic [9:0] ADDR_PAIR_CFG = 10'h058;
  localparam logic [9:0] ADDR_LOCK_LO = 10'h0D0;
  localparam logic [9:0] ADDR_LOCK_HI = 10'h14F;
  localparam logic [7:0] PAGE_WMASK = 8'hC7;
  localparam logic [7:0] IN_EVT_WMASK = 8'h5F;
  localparam logic [7:0] REG_EVT_WMASK = 8'h3F;
  localparam int PAGE_AUTORET_BIT = 7;
  localparam int WRITE_MODE_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam int SLEW_SECOND_LSB = 5;
  localparam int SLEW_FIRST_LSB = 3;
  localparam int CMD_READ_BIT = 7;
  localparam int IN0_DEB_BIT = 3;
  localparam int IN0_POL_BIT = 2;
  localparam int IN1_DEB_BIT = 7;
  localparam int IN1_POL_BIT = 6;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PAIR_CFG = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RAMP_STEP_NS [4] = '{4000, 2000, 1000, 500};
  localparam int unsigned DEBOUNCE_BASE_US = 100;
  localparam int unsigned DEBOUNCE_BASE_CYCLES = DEBOUNCE_BASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_US [8] =
    '{0, 100, 1000, 10000, 50000, 250000, 500000, 1000000};

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} frame_phase_e;

  typedef struct packed {
    logic [1:0] ramp_done;
    logic [1:0] current_limit;
    logic thermal_shutdown_flag;
    logic thermal_warning;
    logic [1:0] output_in_range;
  } reg_status_s;

  typedef struct packed {
    logic [2:0] sclk_sy;
    logic [1:0] cs_sy;
    logic cs_prev;
    logic [1:0] mosi_sy;
    logic [1:0] tw_sy;
    logic [4:0] gpi_s1;
    logic [4:0] gpi_s2;
    logic uv_s1;
    logic uv_s2;
    logic uv_prev;
    reg_status_s rs_s1;
    reg_status_s rs_s2;
    reg_status_s rs_prev;
    frame_phase_e phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic rd;
    logic addr_ok;
    logic [9:0] addr;
    logic [7:0] tx;
    logic miso;
    logic miso_oe_n;
    logic [7:0] page;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] control;
    logic [7:0] pair_cfg;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic [7:0] pend_a;
    logic [7:0] pend_b;
    logic [4:0] gpi_db;
    logic [4:0][19:0] db_cnt;
    logic [19:0] tick_cnt;
    logic tick;
    logic [1:0][5:0] ramp_cnt;
    logic [1:0] ramp_step;
    logic irq_n;
    logic ext_wr;
    logic [9:0] ext_addr;
    logic [7:0] ext_data;
  } state_s;
endpackage

// ---- rtl/pmic_control_event_registers.sv ----
`timescale 1ns/1ns
// Behaviour
// - Auto-return clears page select after access
// - Write-mode bit picks two-wire page/repeated write
// - Two-wire page codes map 256/128-register windows
// - Four-wire page codes map 128-register windows
// - Status reads return live levels, inputs bits 4:0
// - Ramp-done flags low while buck ramps
// - Current-limit flags high while limit reached
// - Thermal shutdown and warning flags track thresholds
// - Output-in-range flags high while voltage good
// - Status change latches event until host clears
// - Unmasked set event asserts interrupt output
// - Writing ones clears exactly those event bits
// - Events during clearing are held, then latched
// - Input event register: undervoltage, inputs (polarity-aware for inputs 0 and 1 only)
// - Regulator events: current, thermal, range loss
// - Input mask bits block interrupt only
// - Current masks block event; others block interrupt
// - Lock bit ignores writes to 0xD0-0x14F, except page control at 0x100
// - Slew code sets 10mV step interval
// - Debounce code selects none to 1000 ms
// - Mode bits for inputs 0 and 1 enable debouncing
module pmic_control_event_registers
  import pmic_regs_pkg::*;
#(
  parameter int unsigned DEB_BASE_CYCLES = DEBOUNCE_BASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic two_wire_sel,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [4:0] general_input,
  input wire logic io_supply_undervoltage,
  input wire reg_status_s regulator_in,
  output logic miso,
  output logic miso_oe_n,
  output logic interrupt_out_n,
  output logic ramp_step_first,
  output logic ramp_step_second,
  output logic ext_wr_strobe,
  output logic [9:0] ext_wr_addr,
  output logic [7:0] ext_wr_data
);

  logic [1:0] rst_sync_ff;
  logic rst_int_n;
  state_s s_ff;
  state_s nxt_s;

  function automatic logic [10:0] map_addr(logic tw, logic [2:0] pg, logic [7:0] a);
    logic [10:0] r;
    r = '0;
    if (tw) begin
      case (pg[2:1])
        2'b00: r = {1'b1, 2'b00, a};
        2'b01: r = {~a[7], 3'b010, a[6:0]};
        2'b10: r = {~a[7], 3'b100, a[6:0]};
        default: r = '0;
      endcase
    end else begin
      case (pg)
        3'b000: r = {1'b1, 3'b000, a[6:0]};
        3'b001: r = {1'b1, 3'b001, a[6:0]};
        3'b010: r = {1'b1, 3'b010, a[6:0]};
        3'b100: r = {1'b1, 3'b100, a[6:0]};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_read(state_s st, logic [9:0] a, logic ok);
    logic [7:0] r;
    r = 8'h00;
    if (ok) begin
      case (a)
        ADDR_PAGE_CTL0, ADDR_PAGE_CTL1, ADDR_PAGE_CTL2, ADDR_PAGE_CTL4: r = st.page;
        ADDR_IN_STATUS: r = {3'b000, st.gpi_db};
        ADDR_REG_STATUS: r = st.rs_s2;
        ADDR_IN_EVENT: r = st.ev_a;
        ADDR_REG_EVENT: r = st.ev_b;
        ADDR_IN_MASK: r = st.mask_a;
        ADDR_REG_MASK: r = st.mask_b;
        ADDR_CONTROL: r = st.control;
        ADDR_PAIR_CFG: r = st.pair_cfg;
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_ff[1];

  always_comb begin
    logic rise;
    logic fall;
    logic bitv;
    logic tw;
    logic [7:0] byte_in;
    logic [10:0] m;
    logic wr_go;
    logic [9:0] wa;
    logic [7:0] wd;
    logic clr_wr;
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [4:0] deb_on;
    logic [4:0] pol;
    logic [4:0] gpi_ev;
    logic [19:0] lim;
    logic [5:0] rlim;
    logic [1:0] spd;
    rise = 1'b0;
    fall = 1'b0;
    bitv = 1'b0;
    tw = 1'b0;
    byte_in = 8'h00;
    m = '0;
    wr_go = 1'b0;
    wa = '0;
    wd = 8'h00;
    clr_wr = 1'b0;
    clr_a = 8'h00;
    clr_b = 8'h00;
    set_a = 8'h00;
    set_b = 8'h00;
    deb_on = 5'h00;
    pol = 5'h00;
    gpi_ev = 5'h00;
    lim = '0;
    rlim = '0;
    spd = '0;
    nxt_s = s_ff;

    // Input synchronisers
    nxt_s.sclk_sy = {s_ff.sclk_sy[1:0], sclk};
    nxt_s.cs_sy = {s_ff.cs_sy[0], cs_n};
    nxt_s.cs_prev = s_ff.cs_sy[1];
    nxt_s.mosi_sy = {s_ff.mosi_sy[0], mosi};
    nxt_s.tw_sy = {s_ff.tw_sy[0], two_wire_sel};
    nxt_s.gpi_s1 = general_input;
    nxt_s.gpi_s2 = s_ff.gpi_s1;
    nxt_s.uv_s1 = io_supply_undervoltage;
    nxt_s.uv_s2 = s_ff.uv_s1;
    nxt_s.rs_s1 = regulator_in;
    nxt_s.rs_s2 = s_ff.rs_s1;
    rise = s_ff.sclk_sy[1] & ~s_ff.sclk_sy[2];
    fall = ~s_ff.sclk_sy[1] & s_ff.sclk_sy[2];
    bitv = s_ff.mosi_sy[1];
    tw = s_ff.tw_sy[1];
    nxt_s.ext_wr = 1'b0;

    // Serial frame engine
    if (s_ff.cs_sy[1]) begin
      nxt_s.phase = PH_CMD;
      nxt_s.bitcnt = 3'd0;
      nxt_s.miso = 1'b0;
      nxt_s.miso_oe_n = 1'b1;
    end else begin
      nxt_s.miso_oe_n = ~((s_ff.phase == PH_DATA) && s_ff.rd);
      if (fall && (s_ff.phase == PH_DATA) && s_ff.rd) begin
        nxt_s.miso = s_ff.tx[7];
        nxt_s.tx = {s_ff.tx[6:0], 1'b0};
      end
      if (rise) begin
        byte_in = {s_ff.shreg[6:0], bitv};
        nxt_s.shreg = byte_in;
        nxt_s.bitcnt = s_ff.bitcnt + 3'd1;
        if (s_ff.bitcnt == 3'd7) begin
          case (s_ff.phase)
            PH_CMD: begin
              nxt_s.rd = byte_in[CMD_READ_BIT];
              nxt_s.phase = PH_ADDR;
            end
            PH_ADDR: begin
              m = map_addr(tw, s_ff.page[2:0], byte_in);
              nxt_s.addr_ok = m[10];
              nxt_s.addr = m[9:0];
              nxt_s.phase = PH_DATA;
              if (s_ff.rd) begin
                nxt_s.tx = reg_read(s_ff, m[9:0], m[10]);
                nxt_s.addr = m[9:0] + 10'd1;
              end
            end
            PH_DATA: begin
              nxt_s.addr = s_ff.addr + 10'd1;
              if (s_ff.rd) begin
                nxt_s.tx = reg_read(s_ff, s_ff.addr, s_ff.addr_ok);
              end else begin
                wr_go = s_ff.addr_ok;
                wa = s_ff.addr;
                wd = byte_in;
                if (tw && s_ff.page[WRITE_MODE_BIT]) begin
                  nxt_s.phase = PH_ADDR;
                end
              end
            end
            default: nxt_s.phase = PH_CMD;
          endcase
        end
      end
    end

    // Register writes
    if (wr_go) begin
      case (wa)
        ADDR_PAGE_CTL0, ADDR_PAGE_CTL1, ADDR_PAGE_CTL2, ADDR_PAGE_CTL4: begin
          nxt_s.page = wd & PAGE_WMASK;
        end
        ADDR_IN_STATUS, ADDR_REG_STATUS: begin
          nxt_s.page = s_ff.page;
        end
        ADDR_IN_EVENT: begin
          clr_wr = 1'b1;
          clr_a = wd & IN_EVT_WMASK;
        end
        ADDR_REG_EVENT: begin
          clr_wr = 1'b1;
          clr_b = wd & REG_EVT_WMASK;
        end
        ADDR_IN_MASK: nxt_s.mask_a = wd & IN_EVT_WMASK;
        ADDR_REG_MASK: nxt_s.mask_b = wd & REG_EVT_WMASK;
        ADDR_CONTROL: nxt_s.control = wd;
        ADDR_PAIR_CFG: nxt_s.pair_cfg = wd;
        default: begin
          if (!(s_ff.control[LOCK_BIT] && wa >= ADDR_LOCK_LO && wa <= ADDR_LOCK_HI)) begin
            nxt_s.ext_wr = 1'b1;
            nxt_s.ext_addr = wa;
            nxt_s.ext_data = wd;
          end
        end
      endcase
    end

    // Debounce base tick
    if (s_ff.tick_cnt >= 20'(DEB_BASE_CYCLES - 1)) begin
      nxt_s.tick_cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 20'd1;
      nxt_s.tick = 1'b0;
    end

    // Input debouncing
    deb_on = {3'b000, s_ff.pair_cfg[IN1_DEB_BIT], s_ff.pair_cfg[IN0_DEB_BIT]};
    pol = {3'b111, s_ff.pair_cfg[IN1_POL_BIT], s_ff.pair_cfg[IN0_POL_BIT]};
    lim = 20'(DEBOUNCE_US[s_ff.control[2:0]] / DEBOUNCE_BASE_US);
    for (int i = 0; i < 5; i++) begin
      if (!deb_on[i] || lim == '0) begin
        nxt_s.gpi_db[i] = s_ff.gpi_s2[i];
        nxt_s.db_cnt[i] = '0;
      end else if (s_ff.gpi_s2[i] == s_ff.gpi_db[i]) begin
        nxt_s.db_cnt[i] = '0;
      end else if (s_ff.tick) begin
        if (s_ff.db_cnt[i] + 20'd1 >= lim) begin
          nxt_s.gpi_db[i] = s_ff.gpi_s2[i];
          nxt_s.db_cnt[i] = '0;
        end else begin
          nxt_s.db_cnt[i] = s_ff.db_cnt[i] + 20'd1;
        end
      end
      gpi_ev[i] = pol[i] ? (nxt_s.gpi_db[i] & ~s_ff.gpi_db[i])
                         : (~nxt_s.gpi_db[i] & s_ff.gpi_db[i]);
    end

    // Event detection
    set_a = {1'b0, s_ff.uv_s2 & ~s_ff.uv_prev, 1'b0, gpi_ev};
    set_b[5:4] = s_ff.rs_s2.current_limit & ~s_ff.rs_prev.current_limit
                 & ~s_ff.mask_b[5:4];
    set_b[3] = s_ff.rs_s2.thermal_shutdown_flag & ~s_ff.rs_prev.thermal_shutdown_flag;
    set_b[2] = s_ff.rs_s2.thermal_warning & ~s_ff.rs_prev.thermal_warning;
    set_b[1:0] = ~s_ff.rs_s2.output_in_range & s_ff.rs_prev.output_in_range;
    nxt_s.uv_prev = s_ff.uv_s2;
    nxt_s.rs_prev = s_ff.rs_s2;

    if (clr_wr) begin
      nxt_s.ev_a = (s_ff.ev_a & ~clr_a) | s_ff.pend_a;
      nxt_s.ev_b = (s_ff.ev_b & ~clr_b) | s_ff.pend_b;
      nxt_s.pend_a = s_ff.pend_a | set_a;
      nxt_s.pend_b = s_ff.pend_b | set_b;
    end else begin
      nxt_s.ev_a = s_ff.ev_a | s_ff.pend_a | set_a;
      nxt_s.ev_b = s_ff.ev_b | s_ff.pend_b | set_b;
      nxt_s.pend_a = 8'h00;
      nxt_s.pend_b = 8'h00;
    end

    // Interrupt output
    nxt_s.irq_n = ~(|(s_ff.ev_a & ~s_ff.mask_a) | |(s_ff.ev_b & ~s_ff.mask_b));

    // Ramp step timing
    nxt_s.ramp_step = 2'b00;
    for (int b = 0; b < 2; b++) begin
      spd = (b == 0) ? s_ff.control[SLEW_FIRST_LSB +: 2] : s_ff.control[SLEW_SECOND_LSB +: 2];
      rlim = 6'(RAMP_STEP_NS[spd] / CLK_PERIOD_NS);
      if (s_ff.rs_s2.ramp_done[b]) begin
        nxt_s.ramp_cnt[b] = '0;
      end else if (s_ff.ramp_cnt[b] + 6'd1 >= rlim) begin
        nxt_s.ramp_cnt[b] = '0;
        nxt_s.ramp_step[b] = 1'b1;
      end else begin
        nxt_s.ramp_cnt[b] = s_ff.ramp_cnt[b] + 6'd1;
      end
    end

    // Page auto-return at end of access
    if (!s_ff.cs_prev && s_ff.cs_sy[1] && s_ff.page[PAGE_AUTORET_BIT]) begin
      nxt_s.page[2:0] = 3'b000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_ff <= '0;
      s_ff.cs_sy <= 2'b11;
      s_ff.cs_prev <= 1'b1;
      s_ff.miso_oe_n <= 1'b1;
      s_ff.irq_n <= 1'b1;
      s_ff.page <= RST_PAGE;
      s_ff.mask_a <= RST_MASK;
      s_ff.mask_b <= RST_MASK;
      s_ff.control <= RST_CONTROL;
      s_ff.pair_cfg <= RST_PAIR_CFG;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign miso = s_ff.miso;
  assign miso_oe_n = s_ff.miso_oe_n;
  assign interrupt_out_n = s_ff.irq_n;
  assign ramp_step_first = s_ff.ramp_step[0];
  assign ramp_step_second = s_ff.ramp_step[1];
  assign ext_wr_strobe = s_ff.ext_wr;
  assign ext_wr_addr = s_ff.ext_addr;
  assign ext_wr_data = s_ff.ext_data;

endmodule

// ---- verification/pmic_control_event_registers_sva.sv ----
`timescale 1ns/1ns
module pmic_cer_sva
  import pmic_regs_pkg::*;
#(
  parameter int unsigned DEB_BASE_CYCLES = DEBOUNCE_BASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic two_wire_sel,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [4:0] general_input,
  input wire logic io_supply_undervoltage,
  input wire reg_status_s regulator_in,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic interrupt_out_n,
  input wire logic ramp_step_first,
  input wire logic ramp_step_second,
  input wire logic ext_wr_strobe,
  input wire logic [9:0] ext_wr_addr,
  input wire logic [7:0] ext_wr_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] fr_cnt, chg_cnt, rd_cnt;
  logic [13:0] in_q;
  wire logic [13:0] in_v = {general_input, io_supply_undervoltage, regulator_in};
  // Cycles since frame, input change, ramp active
  always_ff @(posedge sys_clk) in_q <= in_v;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_cnt <= 8'hFF;
      chg_cnt <= 8'hFF;
      rd_cnt <= 8'hFF;
    end else begin
      fr_cnt <= !cs_n ? 8'h00 : fr_cnt + {7'h00, fr_cnt != 8'hFF};
      chg_cnt <= (in_v != in_q) ? 8'h00 : chg_cnt + {7'h00, chg_cnt != 8'hFF};
      rd_cnt <= !regulator_in.ramp_done[0] ? 8'h00 : rd_cnt + {7'h00, rd_cnt != 8'hFF};
    end
  end
  sequence s_quiet;
    interrupt_out_n && miso_oe_n && !ext_wr_strobe;
  endsequence
  property p_reset_quiet; $rose(rst_n) |-> s_quiet[*2]; endproperty
  property p_irq_cause; $fell(interrupt_out_n) |-> chg_cnt < 8'h50 || fr_cnt < 8'h18; endproperty
  property p_irq_release; $rose(interrupt_out_n) |-> fr_cnt < 8'h18; endproperty
  property p_gap_first; ramp_step_first |=> !ramp_step_first[*4]; endproperty
  property p_gap_second; ramp_step_second |=> !ramp_step_second[*4]; endproperty
  property p_step_cause; ramp_step_first |-> rd_cnt < 8'h08; endproperty
  property p_strobe; ext_wr_strobe |-> fr_cnt < 8'h18 ##1 !ext_wr_strobe; endproperty
  property p_oe_frame; !miso_oe_n |-> fr_cnt < 8'h08; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  a_irq_release: assert property (p_irq_release) else $error("interrupt left alone");
  a_gap_first: assert property (p_gap_first) else $error("first steps too close");
  a_gap_second: assert property (p_gap_second) else $error("second steps too close");
  a_step_cause: assert property (p_step_cause) else $error("step while idle");
  a_strobe: assert property (p_strobe) else $error("stray write strobe");
  a_oe_frame: assert property (p_oe_frame) else $error("miso driven outside frame");
endmodule
bind pmic_control_event_registers pmic_cer_sva #(.DEB_BASE_CYCLES(DEB_BASE_CYCLES)) sva_u (.*);

// ---- verification/serial_host_model.sv ----
`timescale 1ns/1ns
module serial_host_model (
  input wire logic sys_clk,
  input wire logic miso,
  input wire logic miso_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Whole bytes, right aligned, sent from bit nbits-1
  task automatic frame_n(input logic [39:0] sh, input int nbits, output logic [7:0] rdat);
    rdat = 8'h00;
    @(negedge sys_clk);
    cs_n = 1'b0;
    wait_n(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = sh[i];
      wait_n(4);
      sclk = 1'b1;
      wait_n(2);
      if (i < 8) rdat = {rdat[6:0], miso_oe_n ? ~miso : miso};
      wait_n(2);
    end
    sclk = 1'b0;
    wait_n(4);
    cs_n = 1'b1;
    mosi = ~mosi;
    wait_n(6);
  endtask
  // Command, address, one data byte
  task automatic frame(input logic [7:0] cmd, adr, wd, output logic [7:0] rdat);
    frame_n({16'h0000, cmd, adr, wd}, 24, rdat);
  endtask
endmodule

// ---- verification/pmic_control_event_registers_tb.sv ----
`timescale 1ns/1ns
module pmic_control_event_registers_tb
  import pmic_regs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic two_wire_sel = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe_n, interrupt_out_n;
  logic ramp_step_first, ramp_step_second, ext_wr_strobe;
  logic [9:0] ext_wr_addr;
  logic [7:0] ext_wr_data, v, r, w;
  logic [4:0] general_input = 5'h00;
  logic io_supply_undervoltage = 1'b0;
  reg_status_s regulator_in = 8'h00;
  int n_errors = 0;
  int checks_done = 0;
  int n_wr = 0;
  int t, k;
  always #50 sys_clk = ~sys_clk;
  pmic_control_event_registers #(.DEB_BASE_CYCLES(4)) dut_u (.*);
  serial_host_model host_u (.*);
  always @(negedge sys_clk) if (ext_wr_strobe === 1'b1) n_wr++;
  task automatic chk(input string what, input logic [9:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.frame(8'h00, a, d, r);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, exp);
    host_u.frame(8'h80, a, 8'h00, v);
    chk(what, {2'h0, v}, {2'h0, exp});
  endtask
  task automatic clr;
    for (int i = 2; i < 4; i++) begin
      host_u.frame(8'h80, 8'(8'h50 + i), 8'h00, v);
      wr(8'(8'h50 + i), v);
    end
  endtask
  function automatic logic [9:0] gap(input int c);
    return 10'(RAMP_STEP_NS[c] / CLK_PERIOD_NS);
  endfunction
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    cyc(60000);
    n_errors++;
    finish_test;
  end
  initial begin
    r = 8'($urandom(32'h0157));
    cyc(20);
    rst_n = 1'b1;
    cyc(6);
    rchk("page", 8'h00, 8'h00);
    repeat (3) begin
      w = 8'($urandom);
      wr(8'h54, w);
      rchk("in_mask", 8'h54, w & 8'h5F);
      wr(8'h55, w);
      rchk("reg_mask", 8'h55, w & 8'h3F);
      wr(8'h56, w & 8'h7F);
      rchk("control", 8'h56, w & 8'h7F);
      general_input = w[4:0];
      regulator_in = ~w;
      rchk("in_status", 8'h50, {3'h0, w[4:0]});
      rchk("reg_status", 8'h51, ~w);
    end
    wr(8'h56, 8'h00);
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h00);
    general_input = 5'h00;
    regulator_in = 8'h03;
    cyc(10);
    clr;
    chk("irq", interrupt_out_n, 1'b1);
    general_input[4] = 1'b1;
    cyc(10);
    chk("irq", interrupt_out_n, 1'b0);
    rchk("in_event", 8'h52, 8'h10);
    wr(8'h54, 8'h10);
    chk("irq", interrupt_out_n, 1'b1);
    io_supply_undervoltage = 1'b1;
    cyc(10);
    chk("irq", interrupt_out_n, 1'b0);
    rchk("in_event", 8'h52, 8'h50);
    wr(8'h52, 8'h50);
    rchk("in_event", 8'h52, 8'h00);
    wr(8'h55, 8'h30);
    regulator_in = 8'h3C;
    cyc(10);
    rchk("reg_event", 8'h53, 8'h0F);
    regulator_in = 8'h0C;
    wr(8'h55, 8'h00);
    regulator_in = 8'h3C;
    cyc(10);
    rchk("reg_event", 8'h53, 8'h3F);
    wr(8'h53, 8'h05);
    rchk("reg_event", 8'h53, 8'h3A);
    two_wire_sel = 1'b1;
    wr(8'h56, 8'h80);
    wr(8'hD0, 8'hA5);
    chk("ext_count", 10'(n_wr), 10'h000);
    wr(8'h56, 8'h00);
    wr(8'hD0, 8'h5A);
    chk("ext_count", 10'(n_wr), 10'h001);
    chk("ext_addr", ext_wr_addr, 10'h0D0);
    chk("ext_data", {2'h0, ext_wr_data}, 10'h05A);
    two_wire_sel = 1'b0;
    cyc(4);
    wr(8'h00, 8'h01);
    wr(8'h51, 8'h3C);
    chk("ext_addr", ext_wr_addr, 10'h0D1);
    chk("ext_data", {2'h0, ext_wr_data}, 10'h03C);
    chk("ext_count", 10'(n_wr), 10'h002);
    wr(8'h00, 8'h00);
    two_wire_sel = 1'b1;
    cyc(4);
    wr(8'h00, 8'h40);
    host_u.frame_n({8'h00, 8'h54, 8'h11, 8'h55, 8'h22}, 40, r);
    rchk("rep_wr", 8'h54, 8'h11);
    rchk("rep_wr", 8'h55, 8'h22);
    wr(8'h00, 8'h00);
    host_u.frame_n({8'h00, 8'h00, 8'h54, 8'h13, 8'h21}, 32, r);
    rchk("page_wr", 8'h54, 8'h13);
    rchk("page_wr", 8'h55, 8'h21);
    two_wire_sel = 1'b0;
    cyc(4);
    wr(8'h00, 8'h40);
    host_u.frame_n({8'h00, 8'h00, 8'h54, 8'h04, 8'h08}, 32, r);
    rchk("fourw_wr", 8'h54, 8'h04);
    rchk("fourw_wr", 8'h55, 8'h08);
    wr(8'h00, 8'h00);
    regulator_in = 8'h00;
    for (int c = 0; c < 4; c++) begin
      wr(8'h56, 8'((c << 3) | ((3 - c) << 5)));
      for (int b = 0; b < 2; b++) begin
        k = 0;
        t = 0;
        while (k < 2 && t < 200) begin
          @(negedge sys_clk);
          t++;
          if ((b == 0 ? ramp_step_first : ramp_step_second) === 1'b1) begin
            k++;
            if (k == 1) t = 0;
          end
        end
        chk("step_gap", 10'(t), gap(b == 0 ? c : 3 - c));
      end
    end
    regulator_in = 8'hC0;
    cyc(6);
    k = 0;
    repeat (100) begin
      @(negedge sys_clk);
      if (ramp_step_first === 1'b1 || ramp_step_second === 1'b1) k++;
    end
    chk("ramp_idle", 10'(k), 10'h000);
    wr(8'h56, 8'h02);
    wr(8'h58, 8'h4C);
    wr(8'h54, 8'h02);
    clr;
    general_input[1:0] = 2'b11;
    cyc(8);
    general_input[0] = 1'b0;
    rchk("in_event", 8'h52, 8'h02);
    general_input[0] = 1'b1;
    cyc(30);
    chk("irq", interrupt_out_n, 1'b1);
    cyc(40);
    chk("irq", interrupt_out_n, 1'b0);
    wr(8'h00, 8'h82);
    rchk("page", 8'h00, 8'h80);
    finish_test;
  end
endmodule
